//--- shared/sld_pkg.sv
package sld_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_PUMP = 8'h00;
    localparam logic [7:0] ADDR_CLKDUTY = 8'h04;
    localparam logic [7:0] ADDR_MAIN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_SEG_BASE = 8'h20;
    localparam int SEG_WORDS = 8;
    // Reset values
    localparam logic [7:0] PUMP_RESET = 8'h00;
    localparam logic [7:0] CLKDUTY_RESET = 8'h00;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    // Pump register fields
    localparam int PUMP_SRC_BIT = 3;
    localparam int PUMP_VSEL_LSB = 0;
    localparam logic [7:0] PUMP_MASK = 8'h0b;
    // Clock, duty and bias register fields
    localparam int CD_DIV_LSB = 5;
    localparam int CD_DUTY_LSB = 1;
    localparam int CD_BIAS_BIT = 0;
    localparam logic [7:0] CLKDUTY_MASK = 8'he7;
    // Main control register fields
    localparam int MAIN_EN_BIT = 0;
    localparam int MAIN_ISEL_LSB = 1;
    localparam int MAIN_CSRC_LSB = 4;
    localparam int MAIN_TYPE_BIT = 6;
    localparam int MAIN_WAVE_BIT = 7;
    localparam logic [7:0] MAIN_MASK = 8'hf7;
    // Duty codes
    localparam logic [1:0] DUTY_4 = 2'h0;
    localparam logic [1:0] DUTY_6 = 2'h1;
    localparam logic [1:0] DUTY_8 = 2'h2;
    localparam logic [7:0] COM_MASK_4 = 8'h0f;
    localparam logic [7:0] COM_MASK_6 = 8'h3f;
    localparam logic [7:0] COM_MASK_8 = 8'hff;
    // C-type source codes
    localparam logic [1:0] CSRC_PIN = 2'h0;
    // Pump clock divider
    localparam int DIV_BITS = 7;
    localparam logic [2:0] DIV_CODE_MAX = 3'h6;
    // Output level codes, rail index above ground
    localparam int LVL_W = 3;
    localparam logic [2:0] LVL_VSS = 3'h0;
    localparam logic [2:0] LVL_D = 3'h1;
    localparam logic [2:0] LVL_C = 3'h2;
    localparam logic [2:0] LVL_B = 3'h3;
    localparam logic [2:0] LVL_A = 3'h4;
    localparam int MAX_COM = 8;
    // Sub clock ticks per half division
    localparam int HALF_TICKS = 16;
endpackage

//--- src/sld_sub_div.sv
`timescale 1ns/1ps
module sld_sub_div (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sub_clk_i,
    input wire logic [2:0] div_code_i,
    output logic sub_tick_o,
    output logic pump_clk_o
);
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [sld_pkg::DIV_BITS-1:0] cnt_q;
    logic [2:0] sel;

    // Two-stage synchroniser, then edge detect on the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sub_clk_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign sub_tick_o = sync2_q & ~sync3_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (sub_tick_o)
            cnt_q <= cnt_q + 1'b1;
    end

    // Code 0 taps bit 6 (divide by 128); codes 6 and 7 tap bit 0 (divide by 2)
    assign sel = (div_code_i > sld_pkg::DIV_CODE_MAX) ? sld_pkg::DIV_CODE_MAX : div_code_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pump_clk_o <= 1'b0;
        else
            pump_clk_o <= cnt_q[3'h6 - sel];
    end

    chk_div_max_tap : assert property (@(posedge clk_i) disable iff (rst_i)
        (div_code_i == 3'h7) && $stable(div_code_i) |=> pump_clk_o == $past(cnt_q[0]))
        else $error("pump clock tap wrong for top code");
endmodule

//--- src/sld_ctrl.sv
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module sld_ctrl #(
    parameter int NSEG = 32,
    parameter int HALF_TICKS = sld_pkg::HALF_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sub_clk_i,
    input wire logic sleep_i,
    input wire logic startup_i,
    input wire logic wdt_sleep_rst_i,
    output logic [sld_pkg::MAX_COM*sld_pkg::LVL_W-1:0] com_level_o,
    output logic [NSEG*sld_pkg::LVL_W-1:0] seg_level_o,
    output logic [sld_pkg::MAX_COM-1:0] com_oe_n_o,
    output logic seg_oe_n_o,
    output logic [sld_pkg::MAX_COM-1:0] com_release_o,
    output logic r_supply_from_pump_o,
    output logic r_pump_en_o,
    output logic [1:0] pump_voltage_code_o,
    output logic c_pump_en_o,
    output logic c_pump_clk_o,
    output logic r_dc_path_en_o,
    output logic [1:0] c_source_select_o,
    output logic [1:0] bias_current_select_o,
    output logic bias_quarter_o,
    output logic lcd_reset_o
);
    if (NSEG < 1 || NSEG > 32 || HALF_TICKS < 1 || HALF_TICKS > 255)
    begin : g_bad_param
        $error("sld_ctrl: unsupported NSEG or HALF_TICKS");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_TICKS - 1);

    logic [7:0] pump_reg_q;
    logic [7:0] cd_reg_q;
    logic [7:0] main_reg_q;
    logic [NSEG-1:0] seg_data_q [sld_pkg::SEG_WORDS];
    logic [31:0] rd_d;
    logic req;
    logic wr;
    logic seg_hit;
    logic [2:0] seg_idx;
    logic display_enable;
    logic bias_type_select;
    logic wave_b;
    logic [1:0] duty_select;
    logic [2:0] c_pump_clock_div;
    logic lcd_off;
    logic pins_float;
    logic [2:0] last_com;
    logic sub_tick;
    logic pump_clk;
    logic [7:0] tick_cnt_q;
    logic half_q;
    logic [2:0] com_q;
    logic pol_q;
    logic half_end;

    // Wishbone slave, one wait state, ack drops after one cycle
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign seg_hit = (wb_adr_i[7:5] == sld_pkg::ADDR_SEG_BASE[7:5]) && (wb_adr_i[1:0] == 2'h0);
    assign seg_idx = wb_adr_i[4:2];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pump_reg_q <= sld_pkg::PUMP_RESET;
            cd_reg_q <= sld_pkg::CLKDUTY_RESET;
            main_reg_q <= sld_pkg::MAIN_RESET;
        end
        else if (wr && wb_sel_i[0])
        begin
            // Unimplemented bits never stored
            if (wb_adr_i == sld_pkg::ADDR_PUMP)
                pump_reg_q <= wb_dat_i[7:0] & sld_pkg::PUMP_MASK;
            if (wb_adr_i == sld_pkg::ADDR_CLKDUTY)
                cd_reg_q <= wb_dat_i[7:0] & sld_pkg::CLKDUTY_MASK;
            if (wb_adr_i == sld_pkg::ADDR_MAIN)
                main_reg_q <= wb_dat_i[7:0] & sld_pkg::MAIN_MASK;
        end
    end

    // Display data, one word per common, byte lanes honoured
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int w = 0; w < sld_pkg::SEG_WORDS; w++)
                seg_data_q[w] <= '0;
        end
        else if (wr && seg_hit)
        begin
            for (int b = 0; b < NSEG; b++)
            begin
                if (wb_sel_i[b/8])
                    seg_data_q[seg_idx][b] <= wb_dat_i[b];
            end
        end
    end

    always_comb
    begin
        rd_d = 32'h0;
        if (wb_adr_i == sld_pkg::ADDR_PUMP)
            rd_d[7:0] = pump_reg_q;
        else if (wb_adr_i == sld_pkg::ADDR_CLKDUTY)
            rd_d[7:0] = cd_reg_q;
        else if (wb_adr_i == sld_pkg::ADDR_MAIN)
            rd_d[7:0] = main_reg_q;
        else if (wb_adr_i == sld_pkg::ADDR_STATUS)
            rd_d[7:0] = {c_pump_en_o, r_pump_en_o, pol_q, com_q, pins_float, lcd_off};
        else if (seg_hit)
            rd_d[NSEG-1:0] = seg_data_q[seg_idx];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0;
        else if (req)
            wb_dat_o <= rd_d;
    end

    // Field decode
    assign display_enable = main_reg_q[sld_pkg::MAIN_EN_BIT];
    assign bias_type_select = main_reg_q[sld_pkg::MAIN_TYPE_BIT];
    assign wave_b = main_reg_q[sld_pkg::MAIN_WAVE_BIT];
    assign duty_select = cd_reg_q[sld_pkg::CD_DUTY_LSB +: 2];
    assign c_pump_clock_div = cd_reg_q[sld_pkg::CD_DIV_LSB +: 3];
    assign c_source_select_o = main_reg_q[sld_pkg::MAIN_CSRC_LSB +: 2];
    assign bias_current_select_o = main_reg_q[sld_pkg::MAIN_ISEL_LSB +: 2];
    assign r_supply_from_pump_o = pump_reg_q[sld_pkg::PUMP_SRC_BIT];
    assign pump_voltage_code_o = pump_reg_q[sld_pkg::PUMP_VSEL_LSB +: 2];

    // Power control
    assign r_pump_en_o = r_supply_from_pump_o & ~bias_type_select & display_enable;
    assign c_pump_en_o = bias_type_select & display_enable & ~sleep_i
        & (c_source_select_o == sld_pkg::CSRC_PIN);
    assign c_pump_clk_o = c_pump_en_o & pump_clk;
    assign r_dc_path_en_o = display_enable & ~bias_type_select & ~sleep_i;
    assign bias_quarter_o = cd_reg_q[sld_pkg::CD_BIAS_BIT] & ~bias_type_select;

    // Reset and pin state
    assign lcd_off = ~display_enable | sleep_i;
    assign lcd_reset_o = lcd_off | pins_float;
    assign pins_float = (rst_i | startup_i) & ~wdt_sleep_rst_i;

    // Common count from duty; eight commons only for R type
    always_comb
    begin
        case (duty_select)
            sld_pkg::DUTY_6:
            begin
                last_com = 3'h5;
                com_release_o = ~sld_pkg::COM_MASK_6;
            end
            sld_pkg::DUTY_8:
            begin
                last_com = bias_type_select ? 3'h5 : 3'h7;
                com_release_o = bias_type_select ? ~sld_pkg::COM_MASK_6 : ~sld_pkg::COM_MASK_8;
            end
            default:
            begin
                last_com = 3'h3;
                com_release_o = ~sld_pkg::COM_MASK_4;
            end
        endcase
    end

    assign com_oe_n_o = {sld_pkg::MAX_COM{pins_float}} | com_release_o;
    assign seg_oe_n_o = pins_float;

    sld_sub_div u_sub_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sub_clk_i(sub_clk_i),
        .div_code_i(c_pump_clock_div),
        .sub_tick_o(sub_tick),
        .pump_clk_o(pump_clk)
    );

    // Frame sequencer
    assign half_end = sub_tick && (tick_cnt_q == HALF_LAST);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || lcd_off)
            tick_cnt_q <= 8'h0;
        else if (half_end)
            tick_cnt_q <= 8'h0;
        else if (sub_tick)
            tick_cnt_q <= tick_cnt_q + 8'h1;
    end

    // Type A: both polarities inside each division; type B: one per frame
    always_ff @(posedge clk_i)
    begin
        if (rst_i || lcd_off)
        begin
            half_q <= 1'b0;
            com_q <= 3'h0;
            pol_q <= 1'b0;
        end
        else if (com_q > last_com)
        begin
            // Duty shortened under a running frame
            com_q <= 3'h0;
        end
        else if (half_end)
        begin
            if (!wave_b)
            begin
                half_q <= ~half_q;
                pol_q <= ~half_q;
                if (half_q)
                    com_q <= (com_q >= last_com) ? 3'h0 : com_q + 3'h1;
            end
            else
            begin
                half_q <= 1'b0;
                com_q <= (com_q >= last_com) ? 3'h0 : com_q + 3'h1;
                if (com_q >= last_com)
                    pol_q <= ~pol_q;
            end
        end
    end

    function automatic logic [2:0] com_lvl(input logic act, input logic pol, input logic qtr);
        if (act)
            com_lvl = pol ? sld_pkg::LVL_VSS : sld_pkg::LVL_A;
        else if (qtr)
            com_lvl = pol ? sld_pkg::LVL_B : sld_pkg::LVL_D;
        else
            com_lvl = pol ? sld_pkg::LVL_B : sld_pkg::LVL_C;
    endfunction

    function automatic logic [2:0] seg_lvl(input logic on, input logic pol, input logic qtr);
        if (on)
            seg_lvl = pol ? sld_pkg::LVL_A : sld_pkg::LVL_VSS;
        else if (qtr)
            seg_lvl = sld_pkg::LVL_C;
        else
            seg_lvl = pol ? sld_pkg::LVL_C : sld_pkg::LVL_B;
    endfunction

    // Level codes, low during rst_i and while the display is off (lcd_off)
    genvar gc;
    generate
        for (gc = 0; gc < sld_pkg::MAX_COM; gc++)
        begin : g_com
            always_ff @(posedge clk_i)
            begin
                if (rst_i || lcd_off || com_release_o[gc])
                    com_level_o[gc*3 +: 3] <= sld_pkg::LVL_VSS;
                else
                    com_level_o[gc*3 +: 3] <= com_lvl(com_q == 3'(gc), pol_q, bias_quarter_o);
            end
        end
        for (gc = 0; gc < NSEG; gc++)
        begin : g_seg
            always_ff @(posedge clk_i)
            begin
                if (rst_i || lcd_off)
                    seg_level_o[gc*3 +: 3] <= sld_pkg::LVL_VSS;
                else
                    seg_level_o[gc*3 +: 3] <= seg_lvl(seg_data_q[com_q][gc], pol_q,
                        bias_quarter_o);
            end
        end
    endgenerate

    // Checks
    sequence s_req;
        req;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    chk_ack_one_cycle : assert property (@(posedge clk_i) disable iff (rst_i)
        s_req |=> s_ack_once)
        else $error("ack not a single-cycle pulse after request");
    chk_pump_gate : assert property (@(posedge clk_i) disable iff (rst_i)
        r_pump_en_o |-> pump_reg_q[3] && !main_reg_q[6] && main_reg_q[0])
        else $error("R pump enabled while gated off");
    chk_reserved_zero : assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == sld_pkg::ADDR_CLKDUTY |=> wb_dat_o[4:3] == 2'h0)
        else $error("reserved bits read non-zero");
    chk_off_low : assert property (@(posedge clk_i) disable iff (rst_i)
        lcd_off |=> com_level_o == '0 && seg_level_o == '0)
        else $error("outputs not low while display reset");
    chk_float_pins : assert property (@(posedge clk_i)
        startup_i && !wdt_sleep_rst_i |-> &com_oe_n_o && seg_oe_n_o && lcd_reset_o)
        else $error("pins driven during reset");
    chk_release_mask : assert property (@(posedge clk_i) disable iff (rst_i)
        duty_select == 2'h0 |-> com_release_o == 8'hf0 && com_oe_n_o[7:4] == 4'hf)
        else $error("unused commons not released");
    chk_com_range : assert property (@(posedge clk_i) disable iff (rst_i)
        com_q <= last_com || $changed(last_com))
        else $error("active common beyond duty");
    chk_dc_path : assert property (@(posedge clk_i) disable iff (rst_i)
        !main_reg_q[0] |-> !r_dc_path_en_o && !c_pump_en_o)
        else $error("bias path on while disabled");
    chk_typeb_pol : assert property (@(posedge clk_i) disable iff (rst_i)
        wave_b && $stable(wave_b) && !lcd_off && $changed(pol_q) |-> com_q == 3'h0)
        else $error("type B polarity changed mid-frame");
endmodule

//--- tb/sld_glass_model.sv
`timescale 1ns/1ps
module sld_glass_model #(
    parameter int NSEG = 4
) (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic [sld_pkg::MAX_COM*sld_pkg::LVL_W-1:0] com_level_i,
    input wire logic [NSEG*sld_pkg::LVL_W-1:0] seg_level_i,
    input wire logic [sld_pkg::MAX_COM-1:0] com_oe_n_i,
    input wire logic seg_oe_n_i,
    output int max_dc_o
);
    // Net charge on the pixel at common 0, segment 0
    int dc_q;
    int d;
    always @(posedge clk_i)
    begin
        d = dc_q;
        if (!com_oe_n_i[0] && !seg_oe_n_i)
        begin
            d = d + int'(com_level_i[2:0]) - int'(seg_level_i[2:0]);
        end
        if (clear_i)
        begin
            d = 0;
            max_dc_o <= 0;
        end
        else if (d > max_dc_o || -d > max_dc_o)
        begin
            max_dc_o <= (d < 0) ? -d : d;
        end
        dc_q <= d;
    end
endmodule

//--- tb/test_segment_lcd_drive_control.sv
`timescale 1ns/1ps
module test_segment_lcd_drive_control;
    localparam int NS = 4;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic sub = 0;
    logic slp = 0;
    logic stup = 0;
    logic wdt = 0;
    logic clr = 1;
    logic [31:0] rdat;
    logic ack;
    logic [23:0] coml;
    logic [NS*3-1:0] segl;
    logic [7:0] coe_n;
    logic [7:0] rel;
    logic soe_n, rsup, rpen, cpen, cpclk, dcen, bq, lrst;
    logic [1:0] vcode;
    logic [1:0] csrc;
    logic [1:0] isel;
    logic [3:0] sel = 4'hf;
    int fails = 0;
    int compares = 0;
    int seed = 79619;
    int mdc;
    logic [31:0] exp_q[$];

    sld_ctrl #(.NSEG(NS), .HALF_TICKS(2)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sub_clk_i(sub), .sleep_i(slp),
        .startup_i(stup), .wdt_sleep_rst_i(wdt), .com_level_o(coml), .seg_level_o(segl),
        .com_oe_n_o(coe_n), .seg_oe_n_o(soe_n), .com_release_o(rel),
        .r_supply_from_pump_o(rsup), .r_pump_en_o(rpen), .pump_voltage_code_o(vcode),
        .c_pump_en_o(cpen), .c_pump_clk_o(cpclk), .r_dc_path_en_o(dcen),
        .c_source_select_o(csrc), .bias_current_select_o(isel), .bias_quarter_o(bq),
        .lcd_reset_o(lrst));

    sld_glass_model #(.NSEG(NS)) glass (.clk_i(clk_i), .clear_i(clr), .com_level_i(coml),
        .seg_level_i(segl), .com_oe_n_i(coe_n), .seg_oe_n_i(soe_n), .max_dc_o(mdc));

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    always
    begin
        repeat (4) @(posedge clk_i);
        sub <= ~sub;
    end

    task automatic wrap_up;
        if (fails == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
        begin
            fails++;
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    // Read results are compared in order as they appear
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            chk("read data", rdat, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
        end
    end

    task automatic watch(output int chg);
        int act;
        logic [2:0] p;
        chg = 0;
        repeat (8) @(posedge clk_i);
        p = coml[2:0];
        repeat (1600)
        begin
            @(posedge clk_i);
            act = 0;
            for (int k = 0; k < 4; k++)
            begin
                if (coml[3*k+:3] === sld_pkg::LVL_A || coml[3*k+:3] === sld_pkg::LVL_VSS) act++;
            end
            chk("active commons", 32'(act), 1);
            if (coml[2:0] !== p) chg++;
            p = coml[2:0];
        end
    endtask

    initial
    begin
        int a, b, e;
        logic [7:0] v;
        logic [7:0] m;
        repeat (4) @(posedge clk_i);
        chk("com float", coe_n, 8'hff);
        chk("seg float", soe_n, 1);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("com driven", coe_n, {24'h0, ~sld_pkg::COM_MASK_4});
        chk("levels off", {8'h0, coml}, 0);
        chk("display reset", lrst, 1);
        rd(sld_pkg::ADDR_PUMP, 0);
        rd(sld_pkg::ADDR_CLKDUTY, 0);
        rd(sld_pkg::ADDR_MAIN, 0);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            v[1:0] = 2'(i);
            wb(1'b1, sld_pkg::ADDR_PUMP, {24'h0, v});
            rd(sld_pkg::ADDR_PUMP, {24'h0, v & sld_pkg::PUMP_MASK});
            chk("voltage code", vcode, 32'(i));
            chk("pump supply", rsup, v[3]);
            chk("r pump off", rpen, 0);
        end
        wb(1'b1, sld_pkg::ADDR_CLKDUTY, 32'hff);
        rd(sld_pkg::ADDR_CLKDUTY, 32'he7);
        rd(8'h40, 0);
        wb(1'b1, sld_pkg::ADDR_PUMP, 32'h08);
        sel <= 4'he;
        wb(1'b1, sld_pkg::ADDR_PUMP, 32'h0);
        sel <= 4'hf;
        rd(sld_pkg::ADDR_PUMP, 32'h08);
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, sld_pkg::ADDR_MAIN, i[2] ? 32'h41 : 32'h01);
            wb(1'b1, sld_pkg::ADDR_CLKDUTY, {29'h0, i[1:0], 1'b1});
            m = (i[1:0] == 1 || (i[1:0] == 2 && i[2])) ? sld_pkg::COM_MASK_6 :
                i[1:0] == 2 ? sld_pkg::COM_MASK_8 : sld_pkg::COM_MASK_4;
            chk("released commons", rel, {24'h0, ~m});
            chk("quarter bias", bq, !i[2]);
            chk("r pump", rpen, !i[2]);
            chk("c pump", cpen, i[2]);
            chk("display reset", lrst, 0);
        end
        wb(1'b1, sld_pkg::ADDR_MAIN, 32'hff);
        rd(sld_pkg::ADDR_MAIN, 32'hf7);
        chk("c source", csrc, 3);
        chk("bias current", isel, 3);
        chk("c pump other source", cpen, 0);
        wb(1'b1, sld_pkg::ADDR_MAIN, 0);
        chk("r pump disabled", rpen, 0);
        chk("dc path", dcen, 0);
        chk("display reset", lrst, 1);
        wb(1'b1, sld_pkg::ADDR_PUMP, 0);
        wb(1'b1, sld_pkg::ADDR_MAIN, 32'h01);
        chk("r pump pin", rpen, 0);
        wb(1'b1, sld_pkg::ADDR_MAIN, 32'h41);
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, sld_pkg::ADDR_CLKDUTY, {24'h0, 3'(i), 5'h0});
            repeat (16) @(posedge clk_i);
            a = 0;
            b = 0;
            repeat (1024)
            begin
                @(posedge clk_i);
                if (cpclk === 1'b1 && b == 0) a++;
                b = (cpclk === 1'b1);
            end
            e = 128 / (i == 7 ? 2 : (128 >> i));
            chk("pump clock edges", (a >= e - 1 && a <= e + 1), 1);
        end
        wb(1'b1, sld_pkg::ADDR_SEG_BASE, 32'($random(seed)) | 32'h1);
        for (int i = 1; i < 4; i++)
        begin
            wb(1'b1, sld_pkg::ADDR_SEG_BASE + 8'(4 * i), 32'($random(seed)) & ~32'h1);
        end
        wb(1'b1, sld_pkg::ADDR_CLKDUTY, 0);
        wb(1'b1, sld_pkg::ADDR_MAIN, 32'h01);
        clr <= 1'b0;
        watch(a);
        chk("wave a runs", a > 0, 1);
        chk("net dc a", mdc <= 100, 1);
        wb(1'b1, sld_pkg::ADDR_MAIN, 32'h81);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        watch(b);
        chk("wave b slower", b < a, 1);
        chk("net dc b", mdc <= 300, 1);
        slp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("sleep levels", {8'h0, coml}, 0);
        chk("sleep seg", segl, 0);
        chk("sleep driven", coe_n, {24'h0, ~sld_pkg::COM_MASK_4});
        chk("sleep reset", lrst, 1);
        slp <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("reset float", coe_n, 8'hff);
        wdt <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("watchdog driven", coe_n, {24'h0, ~sld_pkg::COM_MASK_4});
        rst_i <= 1'b0;
        wdt <= 1'b0;
        stup <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("startup float", {coe_n, 7'h0, soe_n}, 32'hff01);
        stup <= 1'b0;
        wrap_up();
    end
endmodule
